// [rtl/rms_device.sv]
module rms_device #(
  parameter int unsigned RESET_PULSE_CYC = rms_pkg::RESET_PULSE_CYC,
  parameter int unsigned STRAP_LATCH_CYC = rms_pkg::STRAP_LATCH_CYC
) (
  input  wire logic           clk_i,
  input  wire logic           arst_n_i,
  rms_if.dev                  lnk,
  input  wire logic           undervolt_i,
  input  wire logic           sw_reset_i,
  input  wire logic           clear_to_send_out_i,
  input  wire logic           set_ready_out_i,
  output logic                running_o,
  output logic                ext_reset_o,
  output logic                mode_valid_o,
  output rms_pkg::rms_mode_e  mode_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    RMS_ST_PULSE = 3'b001,
    RMS_ST_LATCH = 3'b010,
    RMS_ST_RUN   = 3'b100
  } rms_dev_st_e;

  typedef struct packed {
    rms_dev_st_e                  st;
    logic [rms_pkg::CNT_W-1:0]    cnt;
    logic [4:0]                   sync1;
    logic [4:0]                   sync2;
    logic                         rst_prev;
    logic                         line_prev;
    logic                         ext;
    logic                         valid;
    rms_pkg::rms_mode_e           mode;
  } rms_dev_s;

  rms_dev_s s_q;
  rms_dev_s s_d;
  logic     in_rst;
  logic     in_dla;
  logic     in_dlb;
  logic     in_cfa;
  logic     in_cfb;
  logic     line_low;

  assign in_rst = s_q.sync2[0];
  assign in_dla = s_q.sync2[1];
  assign in_dlb = s_q.sync2[2];
  assign in_cfa = s_q.sync2[3];
  assign in_cfb = s_q.sync2[4];
  // The driven line reads low while we release it only if someone else pulls it.
  assign line_low = (s_q.st == RMS_ST_RUN) && !lnk.reset_out_n;

  always_comb begin
    s_d          = s_q;
    // Metastable samples never reach the decode below.
    s_d.sync1    = {lnk.cfg_strap_b, lnk.cfg_strap_a, lnk.dl_strap_b_i,
                    lnk.dl_strap_a_i, lnk.ext_reset_in};
    s_d.sync2    = s_q.sync1;
    s_d.rst_prev = in_rst;
    s_d.line_prev = line_low;
    case (s_q.st)
      RMS_ST_PULSE: begin
        s_d.valid = 1'b0;
        s_d.mode  = rms_pkg::RMS_MODE_NONE;
        if (s_q.cnt >= RESET_PULSE_CYC - 1) begin
          s_d.st  = RMS_ST_LATCH;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      RMS_ST_LATCH: begin
        if (s_q.cnt >= STRAP_LATCH_CYC - 1) begin
          // All five pins are taken from the same synchronised sample.
          s_d.st    = RMS_ST_RUN;
          s_d.valid = 1'b1;
          s_d.ext   = !in_rst;
          if (!in_dla && !in_dlb) begin
            s_d.mode = rms_pkg::RMS_MODE_DL;
          end else if (!in_rst && in_cfb) begin
            s_d.mode = in_cfa ? rms_pkg::RMS_MODE_CFG
                              : rms_pkg::RMS_MODE_DATA;
          end else begin
            s_d.mode = rms_pkg::RMS_MODE_DATA;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      RMS_ST_RUN: begin
        if ((s_q.rst_prev && !in_rst) || (line_low && !s_q.line_prev) ||
            undervolt_i || sw_reset_i) begin
          s_d.st    = RMS_ST_PULSE;
          s_d.cnt   = '0;
          s_d.valid = 1'b0;
        end
      end
      default: begin
        s_d.st  = RMS_ST_PULSE;
        s_d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Power-up enters the reset pulse with no host help.
      s_q.st        <= RMS_ST_PULSE;
      s_q.cnt       <= '0;
      s_q.sync1     <= 5'h1F;
      s_q.sync2     <= 5'h1F;
      s_q.rst_prev  <= 1'b1;
      s_q.line_prev <= 1'b0;
      s_q.ext       <= 1'b0;
      s_q.valid     <= 1'b0;
      s_q.mode      <= rms_pkg::RMS_MODE_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // During reset the handshake pins are released so they act as strap inputs.
  // The output rises as the pulse ends, so the strap latch point trails that rise.
  assign lnk.reset_out_n       = (s_q.st != RMS_ST_PULSE);
  assign lnk.dev_dl_strap_a_o  = clear_to_send_out_i;
  assign lnk.dev_dl_strap_b_o  = set_ready_out_i;
  assign lnk.dev_dl_strap_a_oe = (s_q.st == RMS_ST_RUN);
  assign lnk.dev_dl_strap_b_oe = (s_q.st == RMS_ST_RUN);
  assign running_o             = (s_q.st != RMS_ST_PULSE);
  assign ext_reset_o       = s_q.ext;
  assign mode_valid_o      = s_q.valid;
  assign mode_o            = s_q.mode;

endmodule

// [rtl/rms_pkg.sv]
// What this block does
// - Reset on power, undervoltage, software, input, line; line_low never sets (reset_out_n high in RUN).
// - Falling reset-input edge starts device reset.
// - Host pulls reset input low to reset.
// - Release reset output; low input marks external.
// - Reset output pulse lasts 100 to 860 ms.
// - Straps sampled latch delay after output rise.
// - Host holds input 100ms past rise, or 960ms.
// - Short 5-50ms input pulse counts as internal.
// - Short reset starts normally unless download straps low.
// - Handshake outputs become download straps during reset.
// - Config straps evaluated only after external reset.
// - Host applies only documented pin combinations.
// - Three modes: data, configuration, download.
// - Power-up resets device without host action.
// - Host may leave reset input unconnected.
// - Download straps low select download; cfg straps choose.
// - Reset input and four straps latched together.
// - Host drives download straps low only with reset.
package rms_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ              = 100_000_000;
  localparam int unsigned RESET_PULSE_TIME_MS = 100;
  localparam int unsigned RESET_PULSE_MAX_MS  = 860;
  localparam int unsigned STRAP_LATCH_DELAY_US = 18;
  localparam int unsigned STRAP_LATCH_MAX_MS  = 100;
  localparam int unsigned HOST_HOLD_AFTER_MS  = 100;
  localparam int unsigned HOST_LONG_PULSE_MS  = 960;
  localparam int unsigned SHORT_RESET_TIME_MS = 5;
  localparam int unsigned SHORT_RESET_MAX_MS  = 50;

  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // Least times, rounded up (exact at this rate).
  localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_TIME_MS * CYC_PER_MS;
  localparam int unsigned STRAP_LATCH_CYC = STRAP_LATCH_DELAY_US * CYC_PER_US;
  localparam int unsigned HOST_HOLD_CYC   = HOST_HOLD_AFTER_MS * CYC_PER_MS;
  localparam int unsigned SHORT_RESET_CYC = SHORT_RESET_TIME_MS * CYC_PER_MS;
  localparam int unsigned CNT_W           = 32;

  // ****************************************************************
  // Mode encoding
  // ****************************************************************
  typedef enum logic [1:0] {
    RMS_MODE_NONE = 2'h0,
    RMS_MODE_DATA = 2'h1,
    RMS_MODE_CFG  = 2'h2,
    RMS_MODE_DL   = 2'h3
  } rms_mode_e;

  typedef enum logic [1:0] {
    RMS_REQ_NORMAL = 2'h0,
    RMS_REQ_CFG    = 2'h1,
    RMS_REQ_DATA   = 2'h2,
    RMS_REQ_DL     = 2'h3
  } rms_req_e;

endpackage

// [rtl/rms_if.sv]
interface rms_if;
  logic ext_reset_in;
  logic reset_out_n;
  // Each end has its own drive pair; the shared wires are resolved outside.
  logic dl_strap_a_i;
  logic dev_dl_strap_a_o;
  logic dev_dl_strap_a_oe;
  logic host_dl_strap_a_o;
  logic host_dl_strap_a_oe;
  logic dl_strap_b_i;
  logic dev_dl_strap_b_o;
  logic dev_dl_strap_b_oe;
  logic host_dl_strap_b_o;
  logic host_dl_strap_b_oe;
  logic cfg_strap_a;
  logic cfg_strap_b;

  modport dev (
    input  ext_reset_in,
    output reset_out_n,
    input  dl_strap_a_i,
    output dev_dl_strap_a_o,
    output dev_dl_strap_a_oe,
    input  dl_strap_b_i,
    output dev_dl_strap_b_o,
    output dev_dl_strap_b_oe,
    input  cfg_strap_a,
    input  cfg_strap_b
  );

  modport host (
    output ext_reset_in,
    input  reset_out_n,
    input  dl_strap_a_i,
    output host_dl_strap_a_o,
    output host_dl_strap_a_oe,
    input  dl_strap_b_i,
    output host_dl_strap_b_o,
    output host_dl_strap_b_oe,
    output cfg_strap_a,
    output cfg_strap_b
  );
endinterface

// [rtl/rms_host.sv]
module rms_host #(
  parameter int unsigned HOST_HOLD_CYC   = rms_pkg::HOST_HOLD_CYC,
  parameter int unsigned SHORT_RESET_CYC = rms_pkg::SHORT_RESET_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  rms_if.host                   lnk,
  input  wire logic             req_i,
  input  rms_pkg::rms_req_e     req_kind_i,
  output logic                  busy_o,
  output logic                  done_o
);

  typedef enum logic [2:0] {
    RMS_HS_IDLE  = 3'b001,
    RMS_HS_WAITR = 3'b010,
    RMS_HS_HOLD  = 3'b100
  } rms_host_st_e;

  typedef struct packed {
    rms_host_st_e               st;
    logic [rms_pkg::CNT_W-1:0]  cnt;
    rms_pkg::rms_req_e          kind;
    logic                       rst_low;
    logic                       seen_low;
    logic                       done;
  } rms_host_s;

  rms_host_s s_q;
  rms_host_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      RMS_HS_IDLE: begin
        if (req_i) begin
          s_d.st       = RMS_HS_WAITR;
          s_d.kind     = req_kind_i;
          s_d.rst_low  = 1'b1;
          s_d.cnt      = '0;
          s_d.seen_low = 1'b0;
        end
      end
      RMS_HS_WAITR: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (!lnk.reset_out_n) begin
          s_d.seen_low = 1'b1;
        end
        if (s_q.kind == rms_pkg::RMS_REQ_NORMAL &&
            s_q.cnt >= SHORT_RESET_CYC - 1) begin
          // Releasing before the output pulse ends makes it a short reset.
          s_d.rst_low = 1'b0;
          s_d.st      = RMS_HS_IDLE;
          s_d.done    = 1'b1;
        end else if (s_q.seen_low && lnk.reset_out_n) begin
          s_d.st  = RMS_HS_HOLD;
          s_d.cnt = '0;
        end
      end
      RMS_HS_HOLD: begin
        if (s_q.cnt >= HOST_HOLD_CYC - 1) begin
          s_d.rst_low = 1'b0;
          s_d.st      = RMS_HS_IDLE;
          s_d.done    = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: begin
        s_d.st      = RMS_HS_IDLE;
        s_d.rst_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q.st       <= RMS_HS_IDLE;
      s_q.cnt      <= '0;
      s_q.kind     <= rms_pkg::RMS_REQ_NORMAL;
      s_q.rst_low  <= 1'b0;
      s_q.seen_low <= 1'b0;
      s_q.done     <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Download straps are driven only while the reset input is held low.
  assign lnk.ext_reset_in  = !s_q.rst_low;
  assign lnk.host_dl_strap_a_o  = 1'b0;
  assign lnk.host_dl_strap_b_o  = 1'b0;
  assign lnk.host_dl_strap_a_oe = s_q.rst_low && (s_q.kind == rms_pkg::RMS_REQ_DL);
  assign lnk.host_dl_strap_b_oe = s_q.rst_low && (s_q.kind == rms_pkg::RMS_REQ_DL);
  // Only the documented combinations are produced.
  assign lnk.cfg_strap_a   = !(s_q.rst_low && s_q.kind == rms_pkg::RMS_REQ_DATA);
  assign lnk.cfg_strap_b   = 1'b1;
  assign busy_o            = (s_q.st != RMS_HS_IDLE);
  assign done_o            = s_q.done;

endmodule

// [dv/rms_assertions.sv]
module rms_assertions #(
  parameter int unsigned RESET_PULSE_CYC = 200,
  parameter int unsigned STRAP_LATCH_CYC = 20
) (
  input wire logic         clk_i,
  input wire logic         arst_n_i,
  input wire logic         ext_reset_in,
  input wire logic         reset_out_n,
  input wire logic         dl_strap_a_i,
  input wire logic         dl_strap_b_i,
  input wire logic         cfg_strap_a,
  input wire logic         cfg_strap_b,
  input wire logic         mode_valid_o,
  input wire logic         ext_reset_o,
  input rms_pkg::rms_mode_e mode_o
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Every pulse, power-up included, counts exactly RESET_PULSE_CYC; the pulse check allows one spare cycle.
  localparam int LAT_LO = STRAP_LATCH_CYC - 1;
  localparam int LAT_HI = STRAP_LATCH_CYC + 3;
  logic [31:0] lo_q;
  logic [31:0] lo_d;
  logic        dl_hi;
  assign dl_hi = dl_strap_a_i && dl_strap_b_i;
  always_comb begin
    lo_d = reset_out_n ? 32'h0 : lo_q + 32'h1;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_q <= 32'h0;
    end else begin
      lo_q <= lo_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ****************************************************************
  // Checks
  // ****************************************************************
  pulse_length_a: assert property ($rose(reset_out_n) |->
    lo_q >= RESET_PULSE_CYC && lo_q <= RESET_PULSE_CYC + 1) else $error("pulse length");
  fall_reset_a: assert property ($fell(ext_reset_in) && mode_valid_o
    |-> ##[2:5] !reset_out_n) else $error("no reset after input fall");
  latch_time_a: assert property ($rose(reset_out_n)
    |-> ##[LAT_LO:LAT_HI] $rose(mode_valid_o)) else $error("latch time");
  mode_hold_a: assert property (mode_valid_o |=>
    !mode_valid_o || $stable(mode_o)) else $error("mode moved");
  valid_clear_a: assert property (!reset_out_n && $past(!reset_out_n)
    |-> !mode_valid_o) else $error("valid in reset");
  dl_select_a: assert property ($rose(mode_valid_o) && !dl_strap_a_i
    && !dl_strap_b_i |-> mode_o == rms_pkg::RMS_MODE_DL) else $error("download");
  cfg_select_a: assert property ($rose(mode_valid_o) && dl_hi && !ext_reset_in
    && cfg_strap_a && cfg_strap_b |-> mode_o == rms_pkg::RMS_MODE_CFG && ext_reset_o)
    else $error("config");
  data_select_a: assert property ($rose(mode_valid_o) && dl_hi && !ext_reset_in
    && !cfg_strap_a && cfg_strap_b |-> mode_o == rms_pkg::RMS_MODE_DATA) else $error("data");
  internal_kind_a: assert property ($rose(mode_valid_o) && dl_hi && ext_reset_in
    |-> mode_o == rms_pkg::RMS_MODE_DATA && !ext_reset_o) else $error("internal");
endmodule

// [dv/reset_mode_select_bench.sv]
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got %0h want %0h", $time, a, b); end end
module reset_mode_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_i, arst_n_i, uv, sw, req, busy, done, run, ext, mval;
  logic               cts, dsr;
  rms_pkg::rms_req_e  kind;
  rms_pkg::rms_mode_e mode;
  int                 num_errors, checked;
  rms_if lnk ();
  // A released strap wire sits at its pull-up level; any end pulling low wins.
  assign lnk.dl_strap_a_i = (!lnk.dev_dl_strap_a_oe || lnk.dev_dl_strap_a_o) &&
                            (!lnk.host_dl_strap_a_oe || lnk.host_dl_strap_a_o);
  assign lnk.dl_strap_b_i = (!lnk.dev_dl_strap_b_oe || lnk.dev_dl_strap_b_o) &&
                            (!lnk.host_dl_strap_b_oe || lnk.host_dl_strap_b_o);
  rms_device #(.RESET_PULSE_CYC(200), .STRAP_LATCH_CYC(20)) rms_device_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .lnk(lnk), .undervolt_i(uv), .sw_reset_i(sw),
    .clear_to_send_out_i(cts), .set_ready_out_i(dsr), .running_o(run),
    .ext_reset_o(ext), .mode_valid_o(mval), .mode_o(mode));
  rms_host #(.HOST_HOLD_CYC(100), .SHORT_RESET_CYC(50)) rms_host_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .lnk(lnk), .req_i(req), .req_kind_i(kind),
    .busy_o(busy), .done_o(done));
  // The checker's default sizes are the ones the device is built with here.
  rms_assertions rms_assertions_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ext_reset_in(lnk.ext_reset_in),
    .reset_out_n(lnk.reset_out_n), .dl_strap_a_i(lnk.dl_strap_a_i),
    .dl_strap_b_i(lnk.dl_strap_b_i), .cfg_strap_a(lnk.cfg_strap_a),
    .cfg_strap_b(lnk.cfg_strap_b), .mode_valid_o(mval), .ext_reset_o(ext), .mode_o(mode));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_mval(input logic v);
    int n;
    n = 0;
    while (mval !== v && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(mval, v)
  endtask
  task automatic check_mode(input rms_pkg::rms_mode_e m, input logic e);
    `CHK(mode, m)
    `CHK(ext, e)
    `CHK(run, 1'b1)
    `CHK(lnk.reset_out_n, 1'b1)
  endtask
  task automatic host_req(input rms_pkg::rms_req_e k, input rms_pkg::rms_mode_e m,
                          input logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    req  <= 1'b1;
    kind <= k;
    @(posedge clk_i);
    req <= 1'b0;
    #1;
    `CHK(busy, 1'b1)
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(done, 1'b1)
    // A short reset is released long before the pulse ends.
    wait_mval(1'b1);
    check_mode(m, e);
  endtask
  // Either internal source must give a fresh pulse and a data start.
  task automatic internal(input logic use_sw);
    @(posedge clk_i);
    sw <= use_sw;
    uv <= !use_sw;
    @(posedge clk_i);
    sw <= 1'b0;
    uv <= 1'b0;
    wait_mval(1'b0);
    @(posedge clk_i);
    #1;
    `CHK(lnk.reset_out_n, 1'b0)
    wait_mval(1'b1);
    check_mode(rms_pkg::RMS_MODE_DATA, 1'b0);
  endtask
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    conclude();
  end
  initial begin
    {uv, sw, req, num_errors, checked} = '0;
    {cts, dsr} = 2'b11;
    arst_n_i = 1'b0;
    kind = rms_pkg::RMS_REQ_NORMAL;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wait_mval(1'b1);
    check_mode(rms_pkg::RMS_MODE_DATA, 1'b0);
    @(posedge clk_i);
    cts <= 1'b0;
    @(posedge clk_i);
    dsr <= 1'b0;
    #1;
    `CHK(lnk.dl_strap_a_i, 1'b0)
    `CHK(lnk.dl_strap_b_i, 1'b0)
    @(posedge clk_i);
    {cts, dsr} <= 2'b11;
    host_req(rms_pkg::RMS_REQ_CFG, rms_pkg::RMS_MODE_CFG, 1'b1);
    host_req(rms_pkg::RMS_REQ_DATA, rms_pkg::RMS_MODE_DATA, 1'b1);
    host_req(rms_pkg::RMS_REQ_DL, rms_pkg::RMS_MODE_DL, 1'b1);
    host_req(rms_pkg::RMS_REQ_NORMAL, rms_pkg::RMS_MODE_DATA, 1'b0);
    internal(1'b1);
    internal(1'b0);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK(mval, 1'b0)
    `CHK(lnk.reset_out_n, 1'b0)
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    wait_mval(1'b1);
    host_req(rms_pkg::RMS_REQ_DL, rms_pkg::RMS_MODE_DL, 1'b1);
    conclude();
  end
endmodule
